/* logic/clp_top.sv */
`timescale 1ns/10ps
`include "clp_consts.svh"
module clp_top #(
  parameter int unsigned MS_CYCLES = `CLP_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oc_cmp,
  input wire logic missing_motor_cond,
  input wire logic pwm_cycle_start,
  output logic recirc_req,
  output logic fault_out_n,
  output logic oc_reported,
  output logic missing_motor_flag
);
  import clp_pkg::*;

  clp_top_s r_q;
  clp_top_s r_d;
  clp_deg_if dg ();

  logic [3:0] rsp;
  logic [7:0] retry_lim;
  logic hs_mod;
  logic oc_lvl;
  logic oc_ev;
  logic acc;
  logic done;
  logic fault_code;
  logic [31:0] status;

  // Field views of the configuration, comparator level and edge, and APB handshake
  assign rsp = r_q.cfg1[`CLP_RSP_MSB:`CLP_RSP_LSB];
  assign hs_mod = r_q.ctrl[`CLP_HS_BIT];
  assign oc_lvl = r_q.oc_sync[1];
  assign oc_ev = oc_lvl & ~r_q.oc_prev;
  assign acc = psel & penable;
  assign done = acc & r_q.pready;
  // A zero retry count is read as one, so it releases at the first PWM start
  assign retry_lim = (r_q.ctrl[`CLP_RETRY_MSB:0] == 8'h00) ? 8'h01
                                                            : r_q.ctrl[`CLP_RETRY_MSB:0];

  // Codes that drive the fault pin while recirculating
  always_comb begin
    case (rsp)
      `CLP_RSP_NEXT_FLT: fault_code = 1'b1;
      `CLP_RSP_LVL_FLT: fault_code = 1'b1;
      `CLP_RSP_RTY_FLT: fault_code = 1'b1;
      default: fault_code = 1'b0;
    endcase
  end

  // Status word seen by software
  always_comb begin
    status = 32'h00000000;
    status[`CLP_ST_OCREP] = r_q.oc_rep;
    status[`CLP_ST_NOMTR] = dg.flag;
    status[`CLP_ST_RECIRC] = r_q.recirc;
    status[`CLP_ST_FAULT] = ~r_q.fault_n;
  end

  // Deglitch timer sees the synchronised condition only
  assign dg.present = r_q.mm_sync[1];
  assign dg.sel = r_q.cfg1[`CLP_DEG_MSB:`CLP_DEG_LSB];

  clp_deglitch #(
    .MS_CYCLES(MS_CYCLES)
  ) u_deglitch (
    .pclk(pclk),
    .presetn(presetn),
    .dg(dg)
  );

  // Next-state logic: synchronisers, fault policy and APB slave
  always_comb begin
    r_d = r_q;
    // Two-stage synchronisers for the comparator and the detection pin
    r_d.oc_sync = {r_q.oc_sync[0], oc_cmp};
    r_d.oc_prev = r_q.oc_sync[1];
    r_d.mm_sync = {r_q.mm_sync[0], missing_motor_cond};

    // Fault policy state machine
    case (r_q.st)
      CLP_IDLE: begin
        if (oc_ev) begin
          case (rsp)
            `CLP_RSP_NEXT_FLT, `CLP_RSP_NEXT_QUIET: begin
              r_d.st = CLP_NEXT;
            end
            `CLP_RSP_LVL_FLT, `CLP_RSP_LVL_QUIET: begin
              // Without high-side modulation fall back to per-cycle recovery
              r_d.st = hs_mod ? CLP_LEVEL : CLP_NEXT;
            end
            `CLP_RSP_RTY_FLT, `CLP_RSP_RTY_QUIET: begin
              r_d.st = CLP_RETRY;
              r_d.rty_cnt = 8'h00;
            end
            default: begin
              r_d.st = CLP_IDLE;
            end
          endcase
        end
      end
      CLP_NEXT: begin
        if (pwm_cycle_start) begin
          r_d.st = CLP_IDLE;
        end
      end
      CLP_LEVEL: begin
        if (!oc_lvl) begin
          r_d.st = CLP_IDLE;
        end
      end
      CLP_RETRY: begin
        if (pwm_cycle_start) begin
          if ((r_q.rty_cnt + 8'h01) >= retry_lim) begin
            r_d.st = CLP_IDLE;
          end else begin
            r_d.rty_cnt = r_q.rty_cnt + 8'h01;
          end
        end
      end
      default: begin
        r_d.st = CLP_IDLE;
      end
    endcase

    // Drive and pin follow the next state so they line up with it
    r_d.recirc = (r_d.st != CLP_IDLE);
    r_d.fault_n = ~(r_d.recirc & fault_code);

    // APB read phase: answer one cycle into the access phase
    r_d.pready = acc & ~r_q.pready;
    if (acc & ~r_q.pready) begin
      r_d.pslverr = 1'b0;
      case (paddr)
        `CLP_CFG1_ADDR: r_d.prdata = r_q.cfg1;
        `CLP_CTRL_ADDR: r_d.prdata = {23'h000000, r_q.ctrl};
        `CLP_STAT_ADDR: r_d.prdata = status;
        default: begin
          r_d.prdata = 32'h00000000;
          r_d.pslverr = 1'b1;
        end
      endcase
    end

    // APB write takes effect on the completing edge only
    if (done & pwrite) begin
      case (paddr)
        `CLP_CFG1_ADDR: r_d.cfg1 = pwdata;
        `CLP_CTRL_ADDR: r_d.ctrl = pwdata[8:0];
        `CLP_STAT_ADDR: begin
          if (pwdata[`CLP_ST_OCREP]) begin
            r_d.oc_rep = 1'b0;
          end
        end
        default: begin
          r_d.cfg1 = r_q.cfg1;
        end
      endcase
    end

    // Report-only code: sticky status, set after the clear so it wins
    if (oc_lvl && rsp == `CLP_RSP_REPORT) begin
      r_d.oc_rep = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q.st <= CLP_IDLE;
      r_q.oc_sync <= 2'h0;
      r_q.oc_prev <= 1'b0;
      r_q.mm_sync <= 2'h0;
      r_q.cfg1 <= `CLP_CFG1_RST;
      r_q.ctrl <= `CLP_CTRL_RST;
      r_q.rty_cnt <= 8'h00;
      r_q.oc_rep <= 1'b0;
      r_q.recirc <= 1'b0;
      r_q.fault_n <= 1'b1;
      r_q.pready <= 1'b0;
      r_q.pslverr <= 1'b0;
      r_q.prdata <= 32'h00000000;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register; missing_motor_flag from the deglitch timer's register
  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign recirc_req = r_q.recirc;
  assign fault_out_n = r_q.fault_n;
  assign oc_reported = r_q.oc_rep;
  assign missing_motor_flag = dg.flag;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_next_fault: assert property (
    r_q.st == CLP_IDLE && oc_ev && rsp == `CLP_RSP_NEXT_FLT
    |=> recirc_req && !fault_out_n) else $error("code 0 entry wrong");
  a_next_quiet: assert property (
    r_q.st == CLP_IDLE && oc_ev && rsp == `CLP_RSP_NEXT_QUIET
    |=> recirc_req && fault_out_n) else $error("code 1 entry wrong");
  a_next_release: assert property (
    r_q.st == CLP_NEXT && pwm_cycle_start
    |=> !recirc_req && fault_out_n) else $error("no release at PWM start");
  a_level_hold: assert property (
    r_q.st == CLP_LEVEL && oc_lvl |=> recirc_req) else $error("level released early");
  a_level_release: assert property (
    r_q.st == CLP_LEVEL && !oc_lvl |=> !recirc_req) else $error("level not released");
  a_retry_quiet: assert property (
    r_q.st == CLP_IDLE && oc_ev && rsp == `CLP_RSP_RTY_QUIET
    |=> r_q.st == CLP_RETRY && r_q.rty_cnt == 8'h00 && fault_out_n)
    else $error("code 5 entry wrong");
  a_retry_hold: assert property (
    r_q.st == CLP_RETRY && !pwm_cycle_start |=> r_q.st == CLP_RETRY)
    else $error("retry left between periods");
  a_report_only: assert property (
    r_q.st == CLP_IDLE && oc_ev && rsp == `CLP_RSP_REPORT
    |=> !recirc_req && oc_reported) else $error("code 6 not report only");
  a_limit_off: assert property (
    r_q.st == CLP_IDLE && rsp > `CLP_RSP_REPORT
    |=> !recirc_req && fault_out_n) else $error("disabled limit acted");
  a_pin_needs_drive: assert property (
    !fault_out_n |-> recirc_req) else $error("fault pin without recirculation");
endmodule : clp_top

/* logic/clp_consts.svh */
`ifndef CLP_CONSTS_SVH
`define CLP_CONSTS_SVH
// Operation
// - Three-bit deglitch code picks 1,10,25,50,100,250,500 or 1000 ms.
// - Four-bit response code governs running, open-loop and alignment current limits.
// - Code 0 recirculates, asserts fault pin, resumes at next PWM cycle.
// - Code 1 recirculates without fault pin, resumes at next PWM cycle.
// - Codes 2/3 recirculate until current falls; 2 faults, 3 quiet; high-side only.
// - Codes 4/5 recirculate for retry count of PWM cycles; 4 faults, 5 quiet.
// - Code 6 only reports overcurrent in status; drive untouched.
// - Codes 7 to 15 disable the limit: no drive change, no fault.

// Clock and time base
`define CLP_CLK_PERIOD_PS 4000
`define CLP_MS_PS 1000000000
`define CLP_MS_CYCLES (`CLP_MS_PS / `CLP_CLK_PERIOD_PS)
`define CLP_PRE_W 18

// Deglitch times in milliseconds, codes 0 to 7
`define CLP_DEG_MS0 10'h001
`define CLP_DEG_MS1 10'h00A
`define CLP_DEG_MS2 10'h019
`define CLP_DEG_MS3 10'h032
`define CLP_DEG_MS4 10'h064
`define CLP_DEG_MS5 10'h0FA
`define CLP_DEG_MS6 10'h1F4
`define CLP_DEG_MS7 10'h3E8

// Register map: configuration register index, byte address is four times it
`define CLP_CFG1_IDX 12'h092
`define CLP_CFG1_ADDR (`CLP_CFG1_IDX * 12'h004)
`define CLP_CTRL_ADDR 12'h250
`define CLP_STAT_ADDR 12'h254
`define CLP_CFG1_RST 32'h00000000
`define CLP_CTRL_RST 9'h001

// Field positions
`define CLP_DEG_MSB 30
`define CLP_DEG_LSB 28
`define CLP_RSP_MSB 27
`define CLP_RSP_LSB 24
`define CLP_RETRY_MSB 7
`define CLP_HS_BIT 8
`define CLP_ST_OCREP 0
`define CLP_ST_NOMTR 1
`define CLP_ST_RECIRC 2
`define CLP_ST_FAULT 3

// Response codes
`define CLP_RSP_NEXT_FLT 4'h0
`define CLP_RSP_NEXT_QUIET 4'h1
`define CLP_RSP_LVL_FLT 4'h2
`define CLP_RSP_LVL_QUIET 4'h3
`define CLP_RSP_RTY_FLT 4'h4
`define CLP_RSP_RTY_QUIET 4'h5
`define CLP_RSP_REPORT 4'h6
`endif

/* logic/clp_pkg.sv */
package clp_pkg;
  typedef enum logic [3:0] {
    CLP_IDLE = 4'b0001,
    CLP_NEXT = 4'b0010,
    CLP_LEVEL = 4'b0100,
    CLP_RETRY = 4'b1000
  } clp_state_e;

  typedef struct packed {
    clp_state_e st;
    logic [1:0] oc_sync;
    logic oc_prev;
    logic [1:0] mm_sync;
    logic [31:0] cfg1;
    logic [8:0] ctrl;
    logic [7:0] rty_cnt;
    logic oc_rep;
    logic recirc;
    logic fault_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } clp_top_s;

  typedef struct packed {
    logic [17:0] pre;
    logic [9:0] ms;
    logic flag;
  } clp_deg_s;
endpackage : clp_pkg

/* logic/clp_deg_if.sv */
`timescale 1ns/10ps
interface clp_deg_if;
  logic present;
  logic [2:0] sel;
  logic flag;
  modport owner (output present, output sel, input flag);
  modport timer (input present, input sel, output flag);
endinterface : clp_deg_if

/* logic/clp_deglitch.sv */
`timescale 1ns/10ps
`include "clp_consts.svh"
module clp_deglitch #(
  parameter int unsigned MS_CYCLES = `CLP_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  clp_deg_if.timer dg
);
  import clp_pkg::*;

  clp_deg_s r_q;
  clp_deg_s r_d;
  logic [9:0] lim;

  // Deglitch time lookup in whole milliseconds
  always_comb begin
    case (dg.sel)
      3'h0: lim = `CLP_DEG_MS0;
      3'h1: lim = `CLP_DEG_MS1;
      3'h2: lim = `CLP_DEG_MS2;
      3'h3: lim = `CLP_DEG_MS3;
      3'h4: lim = `CLP_DEG_MS4;
      3'h5: lim = `CLP_DEG_MS5;
      3'h6: lim = `CLP_DEG_MS6;
      3'h7: lim = `CLP_DEG_MS7;
      default: lim = `CLP_DEG_MS7;
    endcase
  end

  // Own prescaler restarts with the condition, so no partial first millisecond
  always_comb begin
    r_d = r_q;
    if (!dg.present) begin
      r_d = '0;
    end else if (!r_q.flag) begin
      if (r_q.pre == `CLP_PRE_W'(MS_CYCLES - 1)) begin
        r_d.pre = '0;
        r_d.ms = r_q.ms + 10'h001;
        r_d.flag = (r_q.ms + 10'h001) >= lim;
      end else begin
        r_d.pre = r_q.pre + `CLP_PRE_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign dg.flag = r_q.flag;

  a_flag_needs_cond: assert property (@(posedge pclk) disable iff (!presetn)
    dg.flag |-> $past(dg.present)) else $error("flag without condition");
  a_flag_drops: assert property (@(posedge pclk) disable iff (!presetn)
    !dg.present |=> !dg.flag) else $error("flag held after clear");
  a_deg_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dg.flag) |-> r_q.ms == $past(lim)) else $error("wrong deglitch length");
endmodule : clp_deglitch

/* dv/clp_bridge_model.sv */
`timescale 1ns/10ps
module clp_bridge_model #(
  parameter int DECAY = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load_high,
  input wire logic recirc_req,
  output logic oc_cmp
);
  logic [7:0] cnt_q;
  logic fell_q;
  // Shunt current decays only while the bridge recirculates; stays low until load drops,
  // so a recovered drive never sees a fresh rising edge from the same overload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      fell_q <= 1'b0;
    end else if (!load_high) begin
      cnt_q <= 8'h00;
      fell_q <= 1'b0;
    end else if (cnt_q >= 8'(DECAY)) begin
      fell_q <= 1'b1;
    end else if (recirc_req) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Comparator output
  assign oc_cmp = load_high && !fell_q;
endmodule : clp_bridge_model

/* dv/testbench.sv */
`timescale 1ns/10ps
`include "clp_consts.svh"
module testbench;
  localparam int MSC = 4;
  logic pclk, presetn, psel, penable, pwrite, load_high, mm, pwm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic pready, pslverr, oc_cmp, recirc_req, fault_out_n, oc_reported, flag, er, hs;
  int fails, total_checks, cyc, retry, code;
  int ms[8] = '{1, 10, 25, 50, 100, 250, 500, 1000};

  clp_top #(.MS_CYCLES(MSC)) clp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oc_cmp(oc_cmp), .missing_motor_cond(mm),
    .pwm_cycle_start(pwm), .recirc_req(recirc_req), .fault_out_n(fault_out_n),
    .oc_reported(oc_reported), .missing_motor_flag(flag));
  clp_bridge_model clp_bridge_model_inst (.pclk(pclk), .presetn(presetn),
    .load_high(load_high), .recirc_req(recirc_req), .oc_cmp(oc_cmp));

  task print_verdict;
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task chk_drive(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_drive

  task chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  // APB master: hold the request until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's hang guard ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reference model: recirculation and fault pin after p PWM starts
  // Codes 2 and 3 without high-side modulation recover at the next PWM start
  function automatic logic [1:0] exp_drive(int code, int p, int rty, logic hs);
    int n;
    logic r;
    n = (code < 2 || (code < 4 && !hs)) ? 1 : (code == 4 || code == 5) ? rty : 99;
    r = (code < 6) && (p < n);
    return {r, !(r && (code == 0 || code == 2 || code == 4))};
  endfunction : exp_drive

  task pulse;
    @(posedge pclk);
    pwm <= 1'b1;
    @(posedge pclk);
    pwm <= 1'b0;
  endtask : pulse

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, load_high, mm, pwm} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    void'($urandom(94));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CLP_CFG1_ADDR, 32'h0);
    chk_word(rd, `CLP_CFG1_RST);
    apb(1'b0, `CLP_CTRL_ADDR, 32'h0);
    chk_word(rd, 32'(`CLP_CTRL_RST));
    apb(1'b0, 12'h100, 32'h0);
    chk_flag(er, 1'b1);
    w = $urandom;
    apb(1'b1, `CLP_CFG1_ADDR, w);
    apb(1'b0, `CLP_CFG1_ADDR, 32'h0);
    chk_word(rd, w);
    // Every response code, then codes 2 and 3 again with high-side modulation off
    for (int k = 0; k < 18; k++) begin
      code = (k < 16) ? k : k - 14;
      hs = (k < 16);
      retry = $urandom_range(3, 1);
      apb(1'b1, `CLP_CTRL_ADDR, (32'(hs) << `CLP_HS_BIT) | 32'(retry));
      apb(1'b1, `CLP_CFG1_ADDR, 32'(code) << 24);
      load_high <= 1'b1;
      repeat (6) @(posedge pclk);
      chk_drive({recirc_req, fault_out_n}, exp_drive(code, 0, retry, hs));
      chk_flag(oc_reported, code == 6);
      for (int p = 1; p < 4; p++) begin
        pulse();
        repeat (3) @(posedge pclk);
        chk_drive({recirc_req, fault_out_n}, exp_drive(code, p, retry, hs));
      end
      repeat (30) @(posedge pclk);
      chk_drive({recirc_req, fault_out_n}, 2'b01);
      load_high <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, `CLP_STAT_ADDR, 32'h0);
      chk_word(rd, 32'(code == 6));
      apb(1'b1, `CLP_STAT_ADDR, 32'h1);
    end
    // Every deglitch code, with a glitch that must restart the timer
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, `CLP_CFG1_ADDR, (32'(d) << 28) | 32'h07000000);
      mm <= 1'b1;
      // Two cycles short of the full time, so the glitch never lands in the same step
      repeat (ms[d] * MSC - 2) @(posedge pclk);
      chk_flag(flag, 1'b0);
      mm <= 1'b0;
      repeat (2) @(posedge pclk);
      mm <= 1'b1;
      repeat (ms[d] * MSC - 4) @(posedge pclk);
      chk_flag(flag, 1'b0);
      repeat (10) @(posedge pclk);
      chk_flag(flag, 1'b1);
      apb(1'b0, `CLP_STAT_ADDR, 32'h0);
      chk_word(rd, 32'h00000001 << `CLP_ST_NOMTR);
      mm <= 1'b0;
      repeat (4) @(posedge pclk);
      chk_flag(flag, 1'b0);
    end
    print_verdict();
  end
endmodule : testbench
